// ==== pkg/hub_cfg_defines.svh ====
`ifndef HUB_CFG_DEFINES_SVH
`define HUB_CFG_DEFINES_SVH

// ****************************************
// register offsets
// ****************************************
`define OFS_DEV_CFG      8'h05
`define OFS_CHARGE       8'h06

// ****************************************
// device configuration fields
// ****************************************
`define BIT_STRING_WE    7
`define BIT_SERIAL_WE    6
`define BIT_LPS_DIS      5
`define BIT_FIXED_ONE    4
`define BIT_SHARED       3
`define BIT_REPORT_DIS   2
`define BIT_TMO_OVR      1
`define BIT_FIXED_ZERO   0
`define CHARGE_MSB       3

// ****************************************
// reset and fixed values
// ****************************************
`define RST_STRING_WE    1'b0
`define RST_SERIAL_WE    1'b0
`define RST_LPS_DIS      1'b0
`define RST_TMO_OVR      1'b0
`define TMO_MAX          8'hFF
`define TMO_ZERO         8'h00

`endif

// ==== pkg/hub_cfg_pkg.sv ====
package hub_cfg_pkg;

  // source of a configuration write
  typedef enum logic [1:0] {
    SRC_NONE   = 2'h0,
    SRC_EEPROM = 2'h1,
    SRC_SMBUS  = 2'h2
  } cfg_src_t;

  // one configuration write request
  typedef struct packed {
    logic       wr;
    cfg_src_t   src;
    logic [7:0] addr;
    logic [7:0] data;
  } cfg_req_t;

  // strap capture sequence
  typedef enum logic [1:0] {
    ST_STRAP = 2'b01,
    ST_RUN   = 2'b10
  } strap_st_t;

endpackage

// ==== logic/hub_device_config_regs.sv ====
`include "hub_cfg_defines.svh"

module hub_device_config_regs
  import hub_cfg_pkg::*;
(
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  // configuration mode
  input  wire logic       i2c_mode,
  input  wire logic       smbus_mode,
  // register access
  input  wire cfg_req_t   cfg_req,
  input  wire logic [7:0] cfg_rd_addr,
  output logic      [7:0] cfg_rdata_q,
  // strap pins
  input  wire logic       shared_switch_strap_pin,
  input  wire logic       power_report_strap_pin,
  input  wire logic [3:0] port_power_charge_strap,
  // link power management
  input  wire logic       forced_link_pm_accept,
  input  wire logic       upstream_disconnect,
  output logic            u1u2_permit,
  // downstream timeout
  input  wire logic       sw_timeout_wr,
  input  wire logic [7:0] sw_timeout,
  output logic      [7:0] link_timeout_q,
  // port power and charging
  input  wire logic [3:0] port_power_req,
  output logic      [3:0] port_power_charge_pins,
  output logic      [3:0] charge_port_enable,
  output logic            power_report_disable,
  // write gates for other banks
  output logic            string_write_enable,
  output logic            serial_number_write_enable
);

  // ****************************************
  // state
  // ****************************************
  strap_st_t  st_q;
  logic       lps_dis_q;
  logic       shared_q;
  logic       report_dis_q;
  logic       tmo_ovr_q;
  logic       string_we_q;
  logic       serial_we_q;
  logic [3:0] charge_q;
  logic       forced_seen_q;
  logic [3:0] pins_d;
  logic [7:0] dev_rd;
  logic [7:0] chg_rd;
  logic       src_ok;
  logic       wr_ok;
  logic       wr_dev;
  logic       wr_chg;

  // ****************************************
  // write qualification
  // ****************************************
  // source by mode
  // eeprom only in i2c mode, host only in smbus mode
  assign src_ok = (i2c_mode && cfg_req.src == SRC_EEPROM) ||
                  (smbus_mode && cfg_req.src == SRC_SMBUS);

  // writes before straps settle would race the capture
  assign wr_ok  = cfg_req.wr && src_ok && (st_q == ST_RUN);
  assign wr_dev = wr_ok && (cfg_req.addr == `OFS_DEV_CFG);
  assign wr_chg = wr_ok && (cfg_req.addr == `OFS_CHARGE);

  // ****************************************
  // strap capture sequence
  // ****************************************
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_q <= ST_STRAP;
    end else begin
      case (st_q)
        ST_STRAP: st_q <= ST_RUN;
        ST_RUN:   st_q <= ST_RUN;
        default:  st_q <= ST_STRAP;
      endcase
    end
  end

  // ****************************************
  // device configuration register
  // ****************************************
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      string_we_q <= `RST_STRING_WE;
      serial_we_q <= `RST_SERIAL_WE;
      lps_dis_q   <= `RST_LPS_DIS;
      tmo_ovr_q   <= `RST_TMO_OVR;
    end else if (wr_dev) begin
      string_we_q <= cfg_req.data[`BIT_STRING_WE];
      serial_we_q <= cfg_req.data[`BIT_SERIAL_WE];
      lps_dis_q   <= cfg_req.data[`BIT_LPS_DIS];
      tmo_ovr_q   <= cfg_req.data[`BIT_TMO_OVR];
    end
  end

  // pin levels are sampled by the clock, never by the reset
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      shared_q     <= 1'b0;
      report_dis_q <= 1'b0;
    end else if (st_q == ST_STRAP) begin
      shared_q     <= shared_switch_strap_pin;
      report_dis_q <= power_report_strap_pin;
    end else if (wr_dev) begin
      shared_q     <= cfg_req.data[`BIT_SHARED];
      report_dis_q <= cfg_req.data[`BIT_REPORT_DIS];
    end
  end

  // ****************************************
  // charging support register
  // ****************************************
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      charge_q <= 4'h0;
    end else if (st_q == ST_STRAP) begin
      charge_q <= port_power_charge_strap;
    end else if (wr_chg) begin
      charge_q <= cfg_req.data[`CHARGE_MSB:0];
    end
  end

  assign charge_port_enable = charge_q;

  // ****************************************
  // read path
  // ****************************************
  always_comb begin
    dev_rd                  = 8'h00;
    dev_rd[`BIT_STRING_WE]  = string_we_q;
    dev_rd[`BIT_SERIAL_WE]  = serial_we_q;
    dev_rd[`BIT_LPS_DIS]    = lps_dis_q;
    dev_rd[`BIT_FIXED_ONE]  = 1'b1;
    dev_rd[`BIT_SHARED]     = shared_q;
    dev_rd[`BIT_REPORT_DIS] = report_dis_q;
    dev_rd[`BIT_TMO_OVR]    = tmo_ovr_q;
    dev_rd[`BIT_FIXED_ZERO] = 1'b0;
  end

  assign chg_rd = {4'h0, charge_q};

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cfg_rdata_q <= 8'h00;
    end else begin
      case (cfg_rd_addr)
        `OFS_DEV_CFG: cfg_rdata_q <= dev_rd;
        `OFS_CHARGE:  cfg_rdata_q <= chg_rd;
        default:      cfg_rdata_q <= 8'h00;
      endcase
    end
  end

  // ****************************************
  // write gates for string banks
  // ****************************************
  // string and serial number gates
  assign string_write_enable        = string_we_q;
  assign serial_number_write_enable = serial_we_q;

  // ****************************************
  // link power management
  // ****************************************
  // only a power-on reset or upstream disconnect forgets it
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      forced_seen_q <= 1'b0;
    end else if (forced_link_pm_accept) begin
      forced_seen_q <= 1'b1;
    end else if (upstream_disconnect) begin
      forced_seen_q <= 1'b0;
    end
  end

  assign u1u2_permit = !lps_dis_q || forced_seen_q;

  // ****************************************
  // downstream timeout override
  // ****************************************
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      link_timeout_q <= `TMO_ZERO;
    end else if (sw_timeout_wr) begin
      if (tmo_ovr_q && sw_timeout != `TMO_ZERO) begin
        link_timeout_q <= `TMO_MAX;
      end else begin
        link_timeout_q <= sw_timeout;
      end
    end
  end

  // ****************************************
  // power control pins
  // ****************************************
  // with reporting off the shared pins carry charge enables
  always_comb begin
    pins_d = charge_q;
    if (!report_dis_q) begin
      if (shared_q) begin
        pins_d = {3'b000, |port_power_req};
      end else begin
        pins_d = port_power_req;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      port_power_charge_pins <= 4'h0;
    end else if (st_q == ST_STRAP) begin
      port_power_charge_pins <= 4'h0;
    end else begin
      port_power_charge_pins <= pins_d;
    end
  end

  assign power_report_disable = report_dis_q;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);

  fixed_one_a: assert property (
    cfg_rd_addr == `OFS_DEV_CFG |=> cfg_rdata_q[`BIT_FIXED_ONE])
    else $error("device config bit 4 not one");

  fixed_zero_a: assert property (
    cfg_rd_addr == `OFS_DEV_CFG |=> !cfg_rdata_q[`BIT_FIXED_ZERO])
    else $error("device config bit 0 not zero");

  charge_upper_a: assert property (
    cfg_rd_addr == `OFS_CHARGE |=> cfg_rdata_q[7:4] == 4'h0)
    else $error("charge upper bits not zero");

  string_gate_a: assert property (
    wr_dev |=> string_write_enable == $past(cfg_req.data[`BIT_STRING_WE]))
    else $error("string gate not loaded");

  serial_gate_a: assert property (
    wr_dev |=> serial_number_write_enable == $past(cfg_req.data[`BIT_SERIAL_WE]))
    else $error("serial gate not loaded");

  lps_block_a: assert property (
    wr_dev && cfg_req.data[`BIT_LPS_DIS] && !forced_link_pm_accept && !forced_seen_q
    |=> !u1u2_permit)
    else $error("low power permitted while disabled");

  forced_keep_a: assert property (
    forced_link_pm_accept ##1 !upstream_disconnect [*2] |=> u1u2_permit)
    else $error("forced accept not kept");

  forced_set_a: assert property (
    forced_link_pm_accept |=> u1u2_permit)
    else $error("forced accept not taken");

  shared_strap_a: assert property (
    st_q == ST_STRAP |=> shared_q == $past(shared_switch_strap_pin))
    else $error("shared strap not captured");

  report_strap_a: assert property (
    st_q == ST_STRAP |=> power_report_disable == $past(power_report_strap_pin))
    else $error("report strap not captured");

  ganged_pins_a: assert property (
    st_q == ST_RUN && !report_dis_q && shared_q
    |=> port_power_charge_pins == {3'b000, $past(|port_power_req)})
    else $error("ganged power pins wrong");

  timeout_ovr_a: assert property (
    sw_timeout_wr && tmo_ovr_q && sw_timeout != `TMO_ZERO
    |=> link_timeout_q == `TMO_MAX)
    else $error("timeout not overridden");

  charge_strap_a: assert property (
    st_q == ST_STRAP |=> charge_port_enable == $past(port_power_charge_strap))
    else $error("charge strap not captured");

  charge_write_a: assert property (
    wr_chg |=> charge_port_enable == $past(cfg_req.data[3:0]))
    else $error("charge write lost");

  src_block_a: assert property (
    cfg_req.wr && !src_ok && $stable(lps_dis_q) |=> $stable(lps_dis_q))
    else $error("write from wrong source taken");

  src_charge_a: assert property (
    st_q == ST_RUN && cfg_req.wr && !src_ok |=> $stable(charge_q))
    else $error("charge write from wrong source taken");

  individual_pins_a: assert property (
    st_q == ST_RUN && !report_dis_q && !shared_q
    |=> port_power_charge_pins == $past(port_power_req))
    else $error("individual power pins wrong");

  report_pins_a: assert property (
    st_q == ST_RUN && report_dis_q |=> port_power_charge_pins == $past(charge_q))
    else $error("pins not carrying charge enables");

  timeout_zero_a: assert property (
    sw_timeout_wr && sw_timeout == `TMO_ZERO |=> link_timeout_q == `TMO_ZERO)
    else $error("zero timeout not kept");

  timeout_pass_a: assert property (
    sw_timeout_wr && !tmo_ovr_q |=> link_timeout_q == $past(sw_timeout))
    else $error("timeout not passed through");

  forced_cover: cover property (
    lps_dis_q && forced_link_pm_accept ##1 u1u2_permit);

  dev_write_cover: cover property (wr_dev ##1 string_write_enable);

  timeout_cover: cover property (
    sw_timeout_wr && tmo_ovr_q && sw_timeout == 8'h01);

  ganged_cover: cover property (
    st_q == ST_RUN && shared_q && !report_dis_q && |port_power_req);

endmodule

// ==== tb/cfg_source_model.sv ====
module cfg_source_model
  import hub_cfg_pkg::*;
(
  // clock
  input  wire logic       clk_sys,
  // request from the bench
  input  wire logic       go,
  input  wire cfg_src_t   src,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] data,
  // toward the block
  output cfg_req_t        cfg_req
);
  timeunit 1ns;
  timeprecision 1ns;

  // eeprom load or host write
  // idle addr and data show inverted last values, so a stale copy never passes for data
  always_ff @(posedge clk_sys) begin
    cfg_req.wr   <= go;
    cfg_req.src  <= go ? src : SRC_NONE;
    cfg_req.addr <= go ? addr : ~cfg_req.addr;
    cfg_req.data <= go ? data : ~cfg_req.data;
  end
endmodule

// ==== tb/hub_device_config_regs_test.sv ====
`include "hub_cfg_defines.svh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin err_total++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end

module hub_device_config_regs_test;
  import hub_cfg_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  logic       clk_sys, nrst, i2c_mode, smbus_mode, go;
  cfg_src_t   src;
  logic [7:0] addr, data, cfg_rd_addr, cfg_rdata_q, sw_timeout, link_timeout_q;
  cfg_req_t   cfg_req;
  logic       shared_pin, report_pin, forced, disc, sw_timeout_wr, u1u2_permit;
  logic [3:0] strap, req, pins, charge_en;
  logic       report_dis, string_we, serial_we;
  int         err_total, checked;

  cfg_source_model src_model (.clk_sys(clk_sys), .go(go), .src(src), .addr(addr),
    .data(data), .cfg_req(cfg_req));

  hub_device_config_regs uut (.clk_sys(clk_sys), .nrst(nrst), .i2c_mode(i2c_mode),
    .smbus_mode(smbus_mode), .cfg_req(cfg_req), .cfg_rd_addr(cfg_rd_addr),
    .cfg_rdata_q(cfg_rdata_q), .shared_switch_strap_pin(shared_pin),
    .power_report_strap_pin(report_pin), .port_power_charge_strap(strap),
    .forced_link_pm_accept(forced), .upstream_disconnect(disc),
    .u1u2_permit(u1u2_permit), .sw_timeout_wr(sw_timeout_wr), .sw_timeout(sw_timeout),
    .link_timeout_q(link_timeout_q), .port_power_req(req),
    .port_power_charge_pins(pins), .charge_port_enable(charge_en),
    .power_report_disable(report_dis), .string_write_enable(string_we),
    .serial_number_write_enable(serial_we));

  // ****************************************
  // bus tasks
  // ****************************************
  task automatic tick();
    @(posedge clk_sys);
    #10;
  endtask

  // request is registered by the model one edge before the block takes it
  task automatic wr_reg(input cfg_src_t s, input logic [7:0] a, input logic [7:0] d);
    go = 1'b1; src = s; addr = a; data = d;
    tick();
    go = 1'b0;
    tick();
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    cfg_rd_addr = a;
    tick();
    `CHK("read data", e, cfg_rdata_q)
  endtask

  task automatic tmo(input logic [7:0] v, input logic [7:0] e);
    sw_timeout_wr = 1'b1; sw_timeout = v;
    tick();
    sw_timeout_wr = 1'b0;
    tick();
    `CHK("link timeout", e, link_timeout_q)
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_strap();
    rd_chk(`OFS_DEV_CFG, 8'h18);
    rd_chk(`OFS_CHARGE, 8'h0A);
    `CHK("charge enable", 4'hA, charge_en)
    `CHK("report disable", 1'b0, report_dis)
    `CHK("ganged pins", 4'h1, pins)
    `CHK("string we", 1'b0, string_we)
    `CHK("serial we", 1'b0, serial_we)
    $display("test strap done");
  endtask

  task automatic t_write();
    wr_reg(SRC_SMBUS, `OFS_DEV_CFG, 8'hFF);
    rd_chk(`OFS_DEV_CFG, 8'hFE);
    `CHK("string we", 1'b1, string_we)
    `CHK("serial we", 1'b1, serial_we)
    `CHK("report disable", 1'b1, report_dis)
    `CHK("report off pins", 4'hA, pins)
    wr_reg(SRC_EEPROM, `OFS_DEV_CFG, 8'h00);
    rd_chk(`OFS_DEV_CFG, 8'hFE);
    wr_reg(SRC_SMBUS, `OFS_CHARGE, 8'hFF);
    rd_chk(`OFS_CHARGE, 8'h0F);
    `CHK("charge enable", 4'hF, charge_en)
    rd_chk(8'h07, 8'h00);
    smbus_mode = 1'b0; i2c_mode = 1'b1;
    wr_reg(SRC_EEPROM, `OFS_CHARGE, 8'h05);
    rd_chk(`OFS_CHARGE, 8'h05);
    wr_reg(SRC_EEPROM, `OFS_DEV_CFG, 8'h00);
    rd_chk(`OFS_DEV_CFG, 8'h10);
    $display("test write done");
  endtask

  task automatic t_power();
    req = 4'h6;
    tick();
    `CHK("individual pins", 4'h6, pins)
    wr_reg(SRC_EEPROM, `OFS_DEV_CFG, 8'h08);
    tick();
    `CHK("ganged pins", 4'h1, pins)
    req = 4'h0;
    tick();
    `CHK("ganged off", 4'h0, pins)
    $display("test power done");
  endtask

  task automatic t_timeout();
    wr_reg(SRC_EEPROM, `OFS_DEV_CFG, 8'h02);
    tmo(8'h05, `TMO_MAX);
    tmo(8'h00, `TMO_ZERO);
    tmo(8'h01, `TMO_MAX);
    wr_reg(SRC_EEPROM, `OFS_DEV_CFG, 8'h00);
    tmo(8'h05, 8'h05);
    $display("test timeout done");
  endtask

  task automatic t_linkpm();
    wr_reg(SRC_EEPROM, `OFS_DEV_CFG, 8'h20);
    `CHK("permit blocked", 1'b0, u1u2_permit)
    forced = 1'b1;
    tick();
    forced = 1'b0;
    `CHK("permit forced", 1'b1, u1u2_permit)
    tick();
    `CHK("permit held", 1'b1, u1u2_permit)
    tick();
    `CHK("permit kept", 1'b1, u1u2_permit)
    disc = 1'b1;
    tick();
    disc = 1'b0;
    `CHK("permit dropped", 1'b0, u1u2_permit)
    $display("test linkpm done");
  endtask

  task automatic final_report();
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ****************************************
  // clock, reset, sequence
  // ****************************************
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // whole sequence needs about 60 cycles
  initial begin
    #(100 * 2000);
    err_total++;
    final_report();
  end

  initial begin
    err_total = 0; checked = 0; nrst = 1'b0; go = 1'b0; src = SRC_NONE;
    addr = 8'h00; data = 8'h00; cfg_rd_addr = 8'h00; i2c_mode = 1'b0;
    smbus_mode = 1'b1; shared_pin = 1'b1; report_pin = 1'b0; strap = 4'hA;
    forced = 1'b0; disc = 1'b0; sw_timeout_wr = 1'b0; sw_timeout = 8'h00; req = 4'h4;
    repeat (16) @(posedge clk_sys);
    #10;
    nrst = 1'b1;
    tick();
    tick();
    t_strap();
    t_write();
    t_power();
    t_timeout();
    t_linkpm();
    final_report();
  end
endmodule
